// ===== bst_consts.svh
`ifndef BST_CONSTS_SVH
`define BST_CONSTS_SVH
`define BST_IR_W       4
`define BST_DR_W       8
`define BST_IR_RESET   4'h1
`define BST_IR_CAPTURE 4'h1
`define BST_IR_BYPASS  4'hf
`define BST_FIFO_DEPTH 2
`define BST_CNT_W      2
`define BST_CNT_FULL   2'h2
`define BST_CNT_ONE    2'h1
`define BST_CNT_ZERO   2'h0
`endif

// ===== bst_pkg.sv
`default_nettype none
`include "bst_consts.svh"
package bst_pkg;
  // Gray steps along reset, idle, select-DR, capture, shift
  typedef enum logic [3:0] {
    BST_RESET      = 4'h0,
    BST_IDLE       = 4'h1,
    BST_SEL_DR     = 4'h3,
    BST_CAPTURE_DR = 4'h2,
    BST_SHIFT_DR   = 4'h6,
    BST_EXIT1_DR   = 4'h7,
    BST_PAUSE_DR   = 4'h5,
    BST_EXIT2_DR   = 4'h4,
    BST_UPDATE_DR  = 4'hc,
    BST_SEL_IR     = 4'hd,
    BST_CAPTURE_IR = 4'hf,
    BST_SHIFT_IR   = 4'he,
    BST_EXIT1_IR   = 4'ha,
    BST_PAUSE_IR   = 4'hb,
    BST_EXIT2_IR   = 4'h9,
    BST_UPDATE_IR  = 4'h8
  } bst_state_type;
  typedef logic [`BST_DR_W-1:0] bst_word_type;
endpackage
`default_nettype wire

// ===== bst_test_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "bst_consts.svh"
//////////////////////////////////////////////////////////////////////////////
// Contract
// - Test reset pin low forces the test port controller into its reset state.
// - Mode select sampled at each rising test clock edge steers the controller.
// - Serial test input sampled at each rising test clock edge.
// - Serial test output changes only at falling test clock edges.
// - Test output driven only while a data or instruction scan shifts.
//////////////////////////////////////////////////////////////////////////////
module bst_test_port (
  input  wire logic                ref_clk,
  input  wire logic                rst,
  input  wire logic                clk_en,
  input  wire logic                tck,
  input  wire logic                tms,
  input  wire logic                tdi,
  input  wire logic                trst_n,
  output var  logic                tdo_o,
  output var  logic                tdo_oe,
  input  wire logic                cap_valid,
  input  wire bst_pkg::bst_word_type cap_data,
  output var  logic                cap_ready,
  output var  logic                upd_valid,
  output var  bst_pkg::bst_word_type upd_data,
  input  wire logic                upd_ready
);
  import bst_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; edges only from the second stage onward
  logic [2:0] tck_q;
  logic [1:0] tms_q;
  logic [1:0] tdi_q;
  logic [1:0] trst_q;
  logic       rise;
  logic       fall;
  logic       tap_rst;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tck_q  <= 3'h0;
      tms_q  <= 2'h3;
      tdi_q  <= 2'h0;
      trst_q <= 2'h0;
    end else if (clk_en) begin
      tck_q  <= {tck_q[1:0], tck};
      tms_q  <= {tms_q[0], tms};
      tdi_q  <= {tdi_q[0], tdi};
      trst_q <= {trst_q[0], trst_n};
    end
  end

  assign rise    = clk_en && tck_q[1] && !tck_q[2];
  assign fall    = clk_en && !tck_q[1] && tck_q[2];
  assign tap_rst = rst || !trst_q[1];

  //////////////////////////////////////////////////////////////////////////////
  // Controller
  bst_state_type state_q;
  bst_state_type state_d;
  logic          m;

  always_comb begin
    m = tms_q[1];
    case (state_q)
      BST_RESET:      state_d = m ? BST_RESET     : BST_IDLE;
      BST_IDLE:       state_d = m ? BST_SEL_DR    : BST_IDLE;
      BST_SEL_DR:     state_d = m ? BST_SEL_IR    : BST_CAPTURE_DR;
      BST_CAPTURE_DR: state_d = m ? BST_EXIT1_DR  : BST_SHIFT_DR;
      BST_SHIFT_DR:   state_d = m ? BST_EXIT1_DR  : BST_SHIFT_DR;
      BST_EXIT1_DR:   state_d = m ? BST_UPDATE_DR : BST_PAUSE_DR;
      BST_PAUSE_DR:   state_d = m ? BST_EXIT2_DR  : BST_PAUSE_DR;
      BST_EXIT2_DR:   state_d = m ? BST_UPDATE_DR : BST_SHIFT_DR;
      BST_UPDATE_DR:  state_d = m ? BST_SEL_DR    : BST_IDLE;
      BST_SEL_IR:     state_d = m ? BST_RESET     : BST_CAPTURE_IR;
      BST_CAPTURE_IR: state_d = m ? BST_EXIT1_IR  : BST_SHIFT_IR;
      BST_SHIFT_IR:   state_d = m ? BST_EXIT1_IR  : BST_SHIFT_IR;
      BST_EXIT1_IR:   state_d = m ? BST_UPDATE_IR : BST_PAUSE_IR;
      BST_PAUSE_IR:   state_d = m ? BST_EXIT2_IR  : BST_PAUSE_IR;
      BST_EXIT2_IR:   state_d = m ? BST_UPDATE_IR : BST_SHIFT_IR;
      BST_UPDATE_IR:  state_d = m ? BST_SEL_DR    : BST_IDLE;
      default:        state_d = BST_RESET;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (tap_rst) begin
      state_q <= BST_RESET;
    end else if (rise) begin
      state_q <= state_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Two-entry buffer feeding Capture-DR
  bst_word_type            fifo_q [`BST_FIFO_DEPTH];
  logic                    wr_ptr_q;
  logic                    rd_ptr_q;
  logic [`BST_CNT_W-1:0]   cnt_q;
  logic [`BST_CNT_W-1:0]   cnt_d;
  logic                    push;
  logic                    pop;
  logic                    cap_evt;

  assign cap_evt = rise && state_q == BST_CAPTURE_DR;
  // Tester cannot be stalled, so a capture with an empty buffer loads zero
  assign pop     = cap_evt && cnt_q != `BST_CNT_ZERO;
  assign push    = clk_en && cap_valid && cap_ready;

  always_comb begin
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + `BST_CNT_ONE;
    end else if (pop && !push) begin
      cnt_d = cnt_q - `BST_CNT_ONE;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wr_ptr_q  <= 1'b0;
      rd_ptr_q  <= 1'b0;
      cnt_q     <= `BST_CNT_ZERO;
      cap_ready <= 1'b0;
    end else if (clk_en) begin
      if (push) begin
        fifo_q[wr_ptr_q] <= cap_data;
        wr_ptr_q         <= !wr_ptr_q;
      end
      if (pop) begin
        rd_ptr_q <= !rd_ptr_q;
      end
      cnt_q     <= cnt_d;
      cap_ready <= cnt_d != `BST_CNT_FULL;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Instruction and data shift paths
  logic [`BST_IR_W-1:0] ir_sh_q;
  logic [`BST_IR_W-1:0] ir_q;
  bst_word_type         dr_q;
  logic                 byp_q;
  logic                 bypass;

  assign bypass = ir_q == `BST_IR_BYPASS;

  always_ff @(posedge ref_clk) begin
    if (tap_rst) begin
      ir_sh_q <= `BST_IR_CAPTURE;
      ir_q    <= `BST_IR_RESET;
      dr_q    <= '0;
      byp_q   <= 1'b0;
    end else if (rise) begin
      case (state_q)
        BST_CAPTURE_IR: ir_sh_q <= `BST_IR_CAPTURE;
        BST_SHIFT_IR:   ir_sh_q <= {tdi_q[1], ir_sh_q[`BST_IR_W-1:1]};
        BST_UPDATE_IR:  ir_q    <= ir_sh_q;
        BST_CAPTURE_DR: begin
          byp_q <= 1'b0;
          dr_q  <= pop ? fifo_q[rd_ptr_q] : '0;
        end
        BST_SHIFT_DR: begin
          if (bypass) begin
            byp_q <= tdi_q[1];
          end else begin
            dr_q <= {tdi_q[1], dr_q[`BST_DR_W-1:1]};
          end
        end
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Update-DR words out; a word arriving while one waits replaces it
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      upd_valid <= 1'b0;
      upd_data  <= '0;
    end else if (clk_en) begin
      if (rise && state_q == BST_UPDATE_DR && !bypass) begin
        upd_valid <= 1'b1;
        upd_data  <= dr_q;
      end else if (upd_ready) begin
        upd_valid <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Output pin, moved only on falling edges
  logic shifting;
  logic out_bit;

  assign shifting = state_q == BST_SHIFT_DR || state_q == BST_SHIFT_IR;
  assign out_bit  = state_q == BST_SHIFT_IR ? ir_sh_q[0] : (bypass ? byp_q : dr_q[0]);

  always_ff @(posedge ref_clk) begin
    if (tap_rst) begin
      tdo_o  <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (fall) begin
      tdo_o  <= shifting ? out_bit : 1'b0;
      tdo_oe <= shifting;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence sel_dr_low_rise;
    rise && trst_q[1] && state_q == BST_SEL_DR && !tms_q[1];
  endsequence

  sequence capture_holds;
    (state_q == BST_CAPTURE_DR)[*2];
  endsequence

  trst_forces_reset_a: assert property (
    !trst_q[1] |=> state_q == BST_RESET)
    else $error("test reset did not force reset state");

  tms_steers_a: assert property (
    rise && trst_q[1] && state_q == BST_IDLE && tms_q[1]
      |=> state_q == BST_SEL_DR)
    else $error("mode select did not steer idle");

  tdi_shift_a: assert property (
    rise && trst_q[1] && state_q == BST_SHIFT_DR && !tms_q[1] && !bypass
      |=> dr_q[`BST_DR_W-1] == $past(tdi_q[1]))
    else $error("serial input not sampled into data path");

  tdo_falling_a: assert property (
    !fall && trst_q[1] && !rst |=> $stable(tdo_o) && $stable(tdo_oe))
    else $error("test output moved off a falling edge");

  tdo_float_a: assert property (
    // Enable may only rise on a falling edge taken inside a shift state
    (fall || !tdo_oe) && !(fall && shifting) |=> !tdo_oe)
    else $error("test output driven outside a scan");

  state_hold_a: assert property (
    !rise && trst_q[1] |=> $stable(state_q))
    else $error("controller moved without a rising edge");

  capture_enter_a: assert property (
    sel_dr_low_rise |=> capture_holds)
    else $error("select to capture step wrong");

  fifo_full_a: assert property (
    cnt_q == `BST_CNT_FULL && clk_en && !pop |=> !cap_ready)
    else $error("buffer full but ready high");
endmodule // bst_test_port
`default_nettype wire

// ===== bst_tester.sv
`timescale 1ns/1ps
`default_nettype none
module bst_tester (
  output var  logic tck,
  output var  logic tms,
  output var  logic tdi,
  output var  logic trst_n,
  input  wire logic tdo_pin
);
  // Clock stands low between frames
  initial begin
    tck    = 1'b0;
    tms    = 1'b1;
    tdi    = 1'b0;
    trst_n = 1'b1;
  end
  //////////////////////////////////////////////////////////////////////////////
  // Output read late in the high phase, so a rising-edge change is caught
  task automatic tick(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #200;
    tck = 1'b1;
    #195;
    q = tdo_pin;
    #5;
    tck = 1'b0;
  endtask
  // Four system cycles low, above the two the port needs
  task automatic pulse_trst();
    trst_n = 1'b0;
    #200;
    trst_n = 1'b1;
  endtask
endmodule // bst_tester
`default_nettype wire

// ===== bst_test_port_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module bst_test_port_tb_top;
  import bst_pkg::*;
  logic         ref_clk = 1'b0;
  logic         rst = 1'b1;
  logic         clk_en = 1'b1;
  logic         cap_valid = 1'b0;
  logic         upd_ready = 1'b0;
  bst_word_type cap_data = 8'h00;
  logic         tck, tms, tdi, trst_n, tdo_o, tdo_oe, cap_ready, upd_valid, tdo_pin;
  bst_word_type upd_data;
  int           errors = 0;
  int           total_checks = 0;
  always #25 ref_clk = ~ref_clk;
  // Released line shows the inverse, never a stale value
  assign tdo_pin = tdo_oe ? tdo_o : ~tdo_o;
  bst_test_port uut (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .tck(tck), .tms(tms),
    .tdi(tdi), .trst_n(trst_n), .tdo_o(tdo_o), .tdo_oe(tdo_oe), .cap_valid(cap_valid),
    .cap_data(cap_data), .cap_ready(cap_ready), .upd_valid(upd_valid),
    .upd_data(upd_data), .upd_ready(upd_ready));
  bst_tester tester (.tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo_pin(tdo_pin));
  //////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    if (errors == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk_word(input bst_word_type got, input bst_word_type exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic scan(input int n, input bst_word_type din, output bst_word_type dout);
    logic q;
    dout = 8'h00;
    for (int i = 0; i < n; i++) begin
      tester.tick(i == n - 1, din[i], q);
      dout[i] = q;
    end
  endtask
  task automatic push(input bst_word_type d);
    int i;
    i = 0;
    // Edge between calls so valid never drops and rises in one step
    cyc(1);
    cap_valid = 1'b1;
    cap_data = d;
    while (cap_ready !== 1'b1 && i < 20) begin
      cyc(1);
      i++;
    end
    if (i == 20) begin
      errors++;
      end_of_test();
    end
    cyc(1);
    cap_valid = 1'b0;
  endtask
  // Offer held while frozen must not be taken
  task automatic freeze_chk();
    clk_en = 1'b0;
    cyc(1);
    cap_valid = 1'b1;
    cyc(3);
    cap_valid = 1'b0;
    clk_en = 1'b1;
    cyc(1);
    chk_bit(cap_ready, 1'b1);
  endtask
  // One-bit bypass path; no word leaves through the update side
  task automatic byp_scan(input bst_word_type din);
    logic         q;
    bst_word_type dout;
    tester.tick(1'b1, 1'b0, q);
    tester.tick(1'b0, 1'b0, q);
    tester.tick(1'b0, 1'b0, q);
    scan(8, din, dout);
    chk_word(dout, {din[6:0], 1'b0});
    tester.tick(1'b1, 1'b0, q);
    tester.tick(1'b0, 1'b0, q);
    cyc(2);
    chk_bit(upd_valid, 1'b0);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // From idle, back to idle
  task automatic ir_scan(input logic [3:0] din);
    logic         q;
    bst_word_type dout;
    tester.tick(1'b1, 1'b0, q);
    tester.tick(1'b1, 1'b0, q);
    tester.tick(1'b0, 1'b0, q);
    tester.tick(1'b0, 1'b0, q);
    scan(4, {4'h0, din}, dout);
    chk_word(dout, 8'h01);
    tester.tick(1'b1, 1'b0, q);
    tester.tick(1'b0, 1'b0, q);
  endtask
  // Passes through pause, then stalls the update side
  task automatic dr_scan(input bst_word_type din, input bst_word_type exp);
    logic         q;
    bst_word_type dout;
    tester.tick(1'b1, 1'b0, q);
    tester.tick(1'b0, 1'b0, q);
    tester.tick(1'b0, 1'b0, q);
    scan(8, din, dout);
    chk_word(dout, exp);
    tester.tick(1'b0, 1'b0, q);
    cyc(6);
    chk_bit(tdo_oe, 1'b0);
    tester.tick(1'b1, 1'b0, q);
    tester.tick(1'b1, 1'b0, q);
    tester.tick(1'b0, 1'b0, q);
    chk_bit(upd_valid, 1'b1);
    chk_word(upd_data, din);
    cyc(10);
    chk_bit(upd_valid, 1'b1);
    upd_ready = 1'b1;
    cyc(1);
    upd_ready = 1'b0;
    cyc(1);
    chk_bit(upd_valid, 1'b0);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    logic q;
    cyc(2);
    rst = 1'b0;
    cyc(4);
    chk_bit(tdo_oe, 1'b0);
    chk_bit(upd_valid, 1'b0);
    chk_bit(cap_ready, 1'b1);
    push(8'ha5);
    freeze_chk();
    push(8'h3c);
    cyc(1);
    chk_bit(cap_ready, 1'b0);
    tester.tick(1'b0, 1'b0, q);
    ir_scan(4'h2);
    dr_scan(8'h5a, 8'ha5);
    chk_bit(cap_ready, 1'b1);
    dr_scan(8'hc3, 8'h3c);
    dr_scan(8'h77, 8'h00);
    tester.tick(1'b1, 1'b0, q);
    tester.tick(1'b0, 1'b0, q);
    tester.tick(1'b0, 1'b0, q);
    tester.tick(1'b0, 1'b1, q);
    cyc(6);
    chk_bit(tdo_oe, 1'b1);
    tester.pulse_trst();
    cyc(2);
    chk_bit(tdo_oe, 1'b0);
    tester.tick(1'b0, 1'b0, q);
    ir_scan(4'hf);
    byp_scan(8'h96);
    end_of_test();
  end
endmodule // bst_test_port_tb_top
`default_nettype wire
